//--- hw/pff_pkg.sv
// package: field layout and types for the profiling flags/filters decode
package pff_pkg;

    // ------------------------------------------------------------------
    // flags word field positions
    // ------------------------------------------------------------------
    localparam int FLG_SAMPLE  = 1;
    localparam int FLG_RETIRED = 2;
    localparam int FLG_BRANCH  = 3;
    localparam int FLG_DMISS   = 4;
    localparam int FLG_CORECYC = 5;
    localparam int FLG_REFCYC  = 6;
    localparam int FLG_OVERFLOW_KEEP_WRITING    = 29;
    localparam int FLG_TIME    = 30;
    localparam int FLG_INT     = 31;

    // ------------------------------------------------------------------
    // filters word field positions
    // ------------------------------------------------------------------
    localparam int FLT_LAT_LSB  = 0;
    localparam int FLT_LAT_W    = 8;
    localparam int FLT_CLF      = 8;
    localparam int FLT_SRC_LSB  = 9;  // bridge, remote, dram, misc
    localparam int FLT_SRC_W    = 4;
    localparam int FLT_SKIP_LSB = 25; // mispred, pred, abs, cond, rel
    localparam int FLT_SKIP_W   = 5;
    localparam int FLT_IPI      = 30;
    localparam int FLT_IPF      = 31;

    // latency field scale as a shift: 16 cycles per field unit
    localparam int LAT_SCALE_SHIFT = 4;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    // event kinds offered for qualification
    typedef enum logic [2:0] {
        PFF_EV_SAMPLE,
        PFF_EV_RETIRED,
        PFF_EV_BRANCH,
        PFF_EV_DMISS,
        PFF_EV_CORECYC,
        PFF_EV_REFCYC
    } pff_event_t;

    // candidate event from the core
    typedef struct packed {
        logic        valid;
        pff_event_t  kind;
        logic        addr_hit;   // address inside the filter range
        logic [3:0]  src;        // one-hot source level
        logic [11:0] latency;    // cycles
        logic [4:0]  br_class;   // mispred, pred, abs, cond, rel
    } pff_cand_t;

    // decoded enables
    typedef struct packed {
        logic sample_en;
        logic retired_en;
        logic branch_en;
        logic dmiss_en;
        logic corecyc_en;
        logic refcyc_en;
        logic keep_writing;
        logic time_en;
        logic thresh_int_en;
    } pff_cfg_t;

endpackage

//--- hw/pff_decode.sv
// profiling flags and filters: load, mask write-back, event qualification
`timescale 1ns/10ps

module pff_decode (
    input  wire logic               core_clk,
    input  wire logic               resetn,
    input  wire logic               load_strobe,
    input  wire logic [31:0]        flags_in,
    input  wire logic [31:0]        filters_in,
    input  wire logic [31:0]        feature_avail,
    input  wire logic               time_counter_present,
    input  wire logic [63:0]        perf_time_counter,
    input  wire pff_pkg::pff_cand_t cand,
    output logic                    wb_valid,
    output logic [31:0]             wb_flags,
    output pff_pkg::pff_cfg_t       cfg,
    output logic                    count_event,
    output logic [63:0]             record_time_field
);

    // ------------------------------------------------------------------
    // stored words
    // ------------------------------------------------------------------
    logic [31:0] flags_word;
    logic [31:0] filters_word;
    logic [31:0] next_flags;
    logic [31:0] supported;

    // ------------------------------------------------------------------
    // load mask
    // ------------------------------------------------------------------
    // reserved flags bits never survive, whatever availability says;
    // the mask is applied at the load edge, so a feature that drops
    // out later only takes effect at the next load
    always_comb begin
        supported = 32'h0000_0000;
        supported[pff_pkg::FLG_SAMPLE]  = 1'b1;
        supported[pff_pkg::FLG_RETIRED] = 1'b1;
        supported[pff_pkg::FLG_BRANCH]  = 1'b1;
        supported[pff_pkg::FLG_DMISS]   = 1'b1;
        supported[pff_pkg::FLG_CORECYC] = 1'b1;
        supported[pff_pkg::FLG_REFCYC]  = 1'b1;
        supported[pff_pkg::FLG_OVERFLOW_KEEP_WRITING]    = 1'b1;
        supported[pff_pkg::FLG_TIME]    = time_counter_present;
        supported[pff_pkg::FLG_INT]     = 1'b1;
        next_flags = flags_in & feature_avail & supported;
    end

    // ------------------------------------------------------------------
    // load capture
    // ------------------------------------------------------------------
    // capture on load; filters reserved bits simply never read
    // both words move on one edge, so qualification never mixes an old
    // filters word with a new flags word
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            flags_word   <= pff_pkg::WORD_RESET;
            filters_word <= pff_pkg::WORD_RESET;
        end else if (load_strobe) begin
            flags_word   <= next_flags;
            filters_word <= filters_in;
        end
    end

    // ------------------------------------------------------------------
    // write-back to the control block
    // ------------------------------------------------------------------
    // write-back pulse one cycle after load; the word sent back is the
    // masked one, so software can read which features really came on
    // wb_flags then holds until the next load
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wb_valid <= 1'b0;
            wb_flags <= pff_pkg::WORD_RESET;
        end else begin
            wb_valid <= load_strobe;
            if (load_strobe) begin
                wb_flags <= next_flags;
            end
        end
    end

    // ------------------------------------------------------------------
    // flag decode
    // ------------------------------------------------------------------
    // direct bit picks: the enables follow the stored flags word
    assign cfg.sample_en     = flags_word[pff_pkg::FLG_SAMPLE];
    assign cfg.retired_en    = flags_word[pff_pkg::FLG_RETIRED];
    assign cfg.branch_en     = flags_word[pff_pkg::FLG_BRANCH];
    assign cfg.dmiss_en      = flags_word[pff_pkg::FLG_DMISS];
    assign cfg.corecyc_en    = flags_word[pff_pkg::FLG_CORECYC];
    assign cfg.refcyc_en     = flags_word[pff_pkg::FLG_REFCYC];
    // ring drain in continuous mode is software's job, no guard here
    assign cfg.keep_writing  = flags_word[pff_pkg::FLG_OVERFLOW_KEEP_WRITING];
    assign cfg.time_en       = flags_word[pff_pkg::FLG_TIME];
    assign cfg.thresh_int_en = flags_word[pff_pkg::FLG_INT];

    // ------------------------------------------------------------------
    // filter fields
    // ------------------------------------------------------------------
    logic [7:0]  lat_field;
    logic [11:0] lat_min;
    logic        lvl_en;
    logic [3:0]  src_sel;
    logic [4:0]  skip;
    logic        ip_en;
    logic        ip_inv;

    // field slices of the stored filters word
    // reserved bits 24 to 13 have no slice, so they can never matter
    assign lat_field = filters_word[pff_pkg::FLT_LAT_LSB
                                    +: pff_pkg::FLT_LAT_W];
    assign lvl_en    = filters_word[pff_pkg::FLT_CLF];
    assign src_sel   = filters_word[pff_pkg::FLT_SRC_LSB
                                    +: pff_pkg::FLT_SRC_W];
    assign skip      = filters_word[pff_pkg::FLT_SKIP_LSB
                                    +: pff_pkg::FLT_SKIP_W];
    assign ip_en     = filters_word[pff_pkg::FLT_IPF];
    assign ip_inv    = filters_word[pff_pkg::FLT_IPI];
    // 8-bit field scaled by 16 fits 12 bits exactly, so no clamp
    assign lat_min   = {4'h0, lat_field} << pff_pkg::LAT_SCALE_SHIFT;

    // ------------------------------------------------------------------
    // event qualification
    // ------------------------------------------------------------------
    logic kind_en;
    logic ip_ok;
    logic lat_ok;
    logic lvl_ok;
    logic br_ok;
    logic is_cache;
    logic [3:0] src_take;
    logic [4:0] br_drop;

    // event kind to its enable; the two spare codes never count
    always_comb begin
        unique case (cand.kind)
            pff_pkg::PFF_EV_SAMPLE:  kind_en = cfg.sample_en;
            pff_pkg::PFF_EV_RETIRED: kind_en = cfg.retired_en;
            pff_pkg::PFF_EV_BRANCH:  kind_en = cfg.branch_en;
            pff_pkg::PFF_EV_DMISS:   kind_en = cfg.dmiss_en;
            pff_pkg::PFF_EV_CORECYC: kind_en = cfg.corecyc_en;
            pff_pkg::PFF_EV_REFCYC:  kind_en = cfg.refcyc_en;
            default:                 kind_en = 1'b0;
        endcase
    end

    // only the data miss event touches the caches
    assign is_cache = (cand.kind == pff_pkg::PFF_EV_DMISS);

    // address gate on every kind; invert picks hits outside the range
    assign ip_ok  = !ip_en || (cand.addr_hit ^ ip_inv);

    // latency gate, cache events only; a zero field turns it off
    assign lat_ok = !is_cache || (lat_field == 8'h00)
                    || (cand.latency >= lat_min);

    // ------------------------------------------------------------------
    // per-bit lanes
    // ------------------------------------------------------------------
    // one lane per source level: seen on this access and selected
    for (genvar gs = 0; gs < pff_pkg::FLT_SRC_W; gs++) begin : g_src_lane
        assign src_take[gs] = cand.src[gs] & src_sel[gs];
    end

    // one lane per branch class: seen on this branch and excluded
    for (genvar gb = 0; gb < pff_pkg::FLT_SKIP_W; gb++) begin : g_br_lane
        assign br_drop[gb] = cand.br_class[gb] & skip[gb];
    end

    // level gate, cache events only; no level enable lets all through
    assign lvl_ok = !is_cache || !lvl_en || (|src_take);

    // any excluded class present drops the branch; other kinds pass
    assign br_ok  = (cand.kind != pff_pkg::PFF_EV_BRANCH)
                    || !(|br_drop);

    // ------------------------------------------------------------------
    // count decision
    // ------------------------------------------------------------------
    // registered count decision; the extra cycle keeps the long gate
    // chain off the counter's own path
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            count_event <= 1'b0;
        end else begin
            count_event <= cand.valid && kind_en && ip_ok
                           && lat_ok && lvl_ok && br_ok;
        end
    end

    // ------------------------------------------------------------------
    // record time stamp
    // ------------------------------------------------------------------
    // record time field, zero unless enabled; sampled every cycle so
    // a record built on any edge sees a value at most one cycle old
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            record_time_field <= 64'h0000_0000_0000_0000;
        end else begin
            record_time_field <= cfg.time_en ? perf_time_counter
                                             : 64'h0000_0000_0000_0000;
        end
    end

endmodule

//--- test/pff_decode_sva.sv
// checker: load write-back and event qualification assertions
`timescale 1ns/10ps
module pff_decode_sva (
    input wire logic               core_clk,
    input wire logic               resetn,
    input wire logic               load_strobe,
    input wire logic [31:0]        flags_in,
    input wire logic [31:0]        filters_in,
    input wire logic [31:0]        feature_avail,
    input wire logic               time_counter_present,
    input wire logic [63:0]        perf_time_counter,
    input wire pff_pkg::pff_cand_t cand,
    input wire logic               wb_valid,
    input wire logic [31:0]        wb_flags,
    input wire pff_pkg::pff_cfg_t  cfg,
    input wire logic               count_event,
    input wire logic [63:0]        record_time_field
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic [31:0] flt;
    // shadow of the filters taken at the last load
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) flt <= 32'h0;
        else if (load_strobe) flt <= filters_in;
    end
    wb_pulse_a: assert property (load_strobe |=> wb_valid)
        else $error("no write-back after load");
    wb_cause_a: assert property (wb_valid |-> $past(load_strobe))
        else $error("write-back without load");
    wb_mask_a: assert property (load_strobe |=> wb_flags ==
        ($past(flags_in) & $past(feature_avail)
         & {1'b1, $past(time_counter_present), 30'h2000_007e}))
        else $error("write-back mask wrong");
    cfg_map_a: assert property (
        cfg == {wb_flags[1], wb_flags[2], wb_flags[3], wb_flags[4],
                wb_flags[5], wb_flags[6], wb_flags[29], wb_flags[30],
                wb_flags[31]})
        else $error("enables differ from stored flags");
    time_field_a: assert property (1'b1 |=> record_time_field ==
        ($past(cfg.time_en) ? $past(perf_time_counter) : 64'h0))
        else $error("time field wrong");
    idle_cand_a: assert property (!cand.valid |=> !count_event)
        else $error("count without candidate");
    kind_off_a: assert property (cand.valid
        && cand.kind == pff_pkg::PFF_EV_DMISS && !cfg.dmiss_en
        |=> !count_event)
        else $error("disabled event counted");
    lat_gate_a: assert property (cand.valid
        && cand.kind == pff_pkg::PFF_EV_DMISS && flt[7:0] != 8'h0
        && cand.latency < {flt[7:0], 4'h0} |=> !count_event)
        else $error("short latency counted");
    lvl_gate_a: assert property (cand.valid && flt[8]
        && cand.kind == pff_pkg::PFF_EV_DMISS
        && !(|(cand.src & flt[12:9])) |=> !count_event)
        else $error("unselected source counted");
    br_skip_a: assert property (cand.valid
        && cand.kind == pff_pkg::PFF_EV_BRANCH
        && |(cand.br_class & flt[29:25]) |=> !count_event)
        else $error("excluded branch counted");
    ip_gate_a: assert property (cand.valid && flt[31]
        && cand.addr_hit == flt[30] |=> !count_event)
        else $error("address filter ignored");
endmodule
bind pff_decode pff_decode_sva i_sva (
    .core_clk             (core_clk),
    .resetn               (resetn),
    .load_strobe          (load_strobe),
    .flags_in             (flags_in),
    .filters_in           (filters_in),
    .feature_avail        (feature_avail),
    .time_counter_present (time_counter_present),
    .perf_time_counter    (perf_time_counter),
    .cand                 (cand),
    .wb_valid             (wb_valid),
    .wb_flags             (wb_flags),
    .cfg                  (cfg),
    .count_event          (count_event),
    .record_time_field    (record_time_field)
);

//--- test/pff_cb_model.sv
// model of the in-memory control block flags and filters words
`timescale 1ns/10ps
module pff_cb_model (
    input  wire logic        core_clk,
    input  wire logic        sw_wr,
    input  wire logic [31:0] sw_flags,
    input  wire logic [31:0] sw_filters,
    input  wire logic        wb_valid,
    input  wire logic [31:0] wb_flags,
    output logic [31:0]      flags_in,
    output logic [31:0]      filters_in
);
    // software stores words; the load writes the flags word back
    always_ff @(posedge core_clk) begin
        if (sw_wr) begin
            flags_in <= sw_flags;
            filters_in <= sw_filters;
        end else if (wb_valid) flags_in <= wb_flags;
    end
endmodule

//--- test/tb_top.sv
// testbench: load sequences and candidate qualification checks
`timescale 1ns/10ps
module tb_top;
    logic core_clk = 0, resetn = 0, load_strobe = 0, sw_wr = 0;
    logic time_counter_present = 0, wb_valid, count_event;
    logic [31:0] sw_flags = 0, sw_filters = 0, feature_avail = 0;
    logic [31:0] flags_in, filters_in, wb_flags;
    logic [63:0] perf_time_counter = 64'h0123_4567_89ab_cdef;
    logic [63:0] record_time_field;
    pff_pkg::pff_cand_t cand = '0;
    pff_pkg::pff_cfg_t  cfg;
    int n_mismatch = 0, total_checks = 0;
    localparam logic [31:0] F = 32'hffff_ffff;
    always #12.5 core_clk = ~core_clk;
    pff_decode i_dut (
        .core_clk             (core_clk),
        .resetn               (resetn),
        .load_strobe          (load_strobe),
        .flags_in             (flags_in),
        .filters_in           (filters_in),
        .feature_avail        (feature_avail),
        .time_counter_present (time_counter_present),
        .perf_time_counter    (perf_time_counter),
        .cand                 (cand),
        .wb_valid             (wb_valid),
        .wb_flags             (wb_flags),
        .cfg                  (cfg),
        .count_event          (count_event),
        .record_time_field    (record_time_field)
    );
    pff_cb_model i_cb (
        .core_clk   (core_clk),
        .sw_wr      (sw_wr),
        .sw_flags   (sw_flags),
        .sw_filters (sw_filters),
        .wb_valid   (wb_valid),
        .wb_flags   (wb_flags),
        .flags_in   (flags_in),
        .filters_in (filters_in)
    );
    task chk(input logic [63:0] s, input logic [63:0] e);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // store words in memory, pulse the load, check the write-back
    task ld(input logic [31:0] f, t, a, input logic p);
        logic [31:0] e;
        e = f & a & {1'b1, p, 30'h2000_007e};
        @(posedge core_clk) begin
            sw_wr <= 1; sw_flags <= f; sw_filters <= t;
            feature_avail <= a; time_counter_present <= p;
        end
        @(posedge core_clk) begin sw_wr <= 0; load_strobe <= 1; end
        @(posedge core_clk) load_strobe <= 0;
        #1 chk(wb_valid, 1'b1);
        chk(wb_flags, e);
        @(posedge core_clk) #1 chk(flags_in, e);
        chk(wb_valid, 1'b0);
    endtask
    task cnd(input pff_pkg::pff_event_t k, input logic h,
             input logic [3:0] s, input logic [11:0] l,
             input logic [4:0] b, input logic x);
        @(posedge core_clk) cand <= '{1'b1, k, h, s, l, b};
        @(posedge core_clk) cand.valid <= 1'b0;
        #1 chk(count_event, x);
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        resetn <= 1;
        // nothing loaded yet: every enable and the write-back stay clear
        #1 chk(cfg, 9'h000);
        chk(wb_flags, 32'h0);
        ld(F, 32'h0, F, 0);
        chk(cfg, 9'h1fd);
        chk(record_time_field, 64'h0);
        ld(F, 32'h0, 32'h4000_0024, 1);
        chk(cfg, 9'h092);
        @(posedge core_clk);
        #1 chk(record_time_field, perf_time_counter);
        $display("test load done");
        ld(F, 32'h2, F, 1);
        cnd(pff_pkg::PFF_EV_DMISS, 0, 4'h1, 12'h020, 5'h0, 1);
        cnd(pff_pkg::PFF_EV_DMISS, 0, 4'h1, 12'h01f, 5'h0, 0);
        ld(F, 32'h0000_0500, F, 1);
        cnd(pff_pkg::PFF_EV_DMISS, 0, 4'h2, 12'h000, 5'h0, 1);
        cnd(pff_pkg::PFF_EV_DMISS, 0, 4'h1, 12'h000, 5'h0, 0);
        cnd(pff_pkg::PFF_EV_BRANCH, 0, 4'h1, 12'h000, 5'h0, 1);
        for (int i = 0; i < 5; i++) begin
            ld(F, 32'h1 << (25 + i), F, 1);
            cnd(pff_pkg::PFF_EV_BRANCH, 0, 0, 0, 5'h1 << i, 0);
            cnd(pff_pkg::PFF_EV_BRANCH, 0, 0, 0, ~(5'h1 << i), 1);
            cnd(pff_pkg::PFF_EV_DMISS, 0, 0, 0, 5'h1 << i, 1);
        end
        $display("test filters done");
        ld(32'h0, 32'h0, F, 1);
        for (int i = 0; i < 6; i++)
            cnd(pff_pkg::pff_event_t'(i), 1, 0, 0, 0, 0);
        ld(F, 32'hc000_0000, F, 1);
        for (int i = 0; i < 6; i++) begin
            cnd(pff_pkg::pff_event_t'(i), 0, 0, 0, 0, 1);
            cnd(pff_pkg::pff_event_t'(i), 1, 0, 0, 0, 0);
        end
        ld(F, 32'h8000_0000, F, 1);
        cnd(pff_pkg::PFF_EV_RETIRED, 1, 0, 0, 0, 1);
        cnd(pff_pkg::PFF_EV_RETIRED, 0, 0, 0, 0, 0);
        // all flags cleared: every enable drops and a retired hit is not counted
        ld(32'h0, 32'h0, F, 1);
        chk(cfg, 9'h000);
        cnd(pff_pkg::PFF_EV_RETIRED, 1, 0, 0, 0, 0);
        $display("test events done");
        end_of_test();
    end
endmodule
